// *** src/pio_ports.sv ***
// Top of the five parallel ports: register port, read mux, module sharing.
// Assumes pins and module controls are synchronous to clk; one clock only.
//
// Chosen here: strobed register access.
`timescale 1ns/100ps
`include "pio_defines.svh"

// Overview of operation
// - 21 pins, five ports, each bit direction-selectable
// - Ports A, C, D have input pullups
// - Pullup off while output, back on input
// - Port A four bits, shared with keypad
// - Port A latches survive reset
// - Port A direction register sets pin direction
// - Keypad enable makes port A pin interrupt input
// - Port C direction: bits 1:0, reset zero
// - Port D direction: bits 6:0, reset zero
// - Port E latch: bits 1:0, survive reset
// - Port E direction: bits 1:0, reset zero
// - Port A pullup enables: bits 3:0, reset zero
// - Port C pullup enables: bits 1:0, reset zero
// - Port D pullup enables: bits 6:0, reset zero
// - Pins shared with converter, serial, timers
// - Direction one drives; reset makes all inputs
// - Read: latch if output, pin if input
module pio_ports (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Register port
  input  wire pio_pkg::pio_addr_t addr,
  input  wire pio_pkg::pio_byte_t wdata,
  input  wire logic             wr_strobe,
  input  wire logic             rd_strobe,
  output pio_pkg::pio_byte_t    rd_data,
  // Port A pins
  input  wire logic [3:0]       port_a_in,
  output logic      [3:0]       port_a_out,
  output logic      [3:0]       port_a_oe,
  output logic      [3:0]       port_a_pullup,
  // Port B pins
  input  wire logic [5:0]       port_b_in,
  output logic      [5:0]       port_b_out,
  output logic      [5:0]       port_b_oe,
  // Port C pins
  input  wire logic [1:0]       port_c_in,
  output logic      [1:0]       port_c_out,
  output logic      [1:0]       port_c_oe,
  output logic      [1:0]       port_c_pullup,
  // Port D pins
  input  wire logic [6:0]       port_d_in,
  output logic      [6:0]       port_d_out,
  output logic      [6:0]       port_d_oe,
  output logic      [6:0]       port_d_pullup,
  // Port E pins
  input  wire logic [1:0]       port_e_in,
  output logic      [1:0]       port_e_out,
  output logic      [1:0]       port_e_oe,
  // Keypad interrupt module
  input  wire logic [3:0]       keypad_irq_enables,
  output logic      [3:0]       keypad_inputs,
  // Analog converter
  input  wire logic [5:0]       converter_channel_select,
  // Serial peripheral (D3:0), timer_one (D5:4), timer_two (D6)
  input  wire logic [6:0]       port_d_alt_en,
  input  wire logic [6:0]       port_d_alt_out,
  input  wire logic [6:0]       port_d_alt_oe,
  output logic      [6:0]       port_d_alt_in,
  // Async serial module (E0 transmit, E1 receive)
  input  wire logic [1:0]       port_e_alt_en,
  input  wire logic [1:0]       port_e_alt_out,
  input  wire logic [1:0]       port_e_alt_oe,
  output logic      [1:0]       port_e_alt_in
);

  // =====================================================================
  // Address decode
  wire hit_a_data = addr == `PIO_OFS_PORT_A_DATA;
  wire hit_b_data = addr == `PIO_OFS_PORT_B_DATA;
  wire hit_c_data = addr == `PIO_OFS_PORT_C_DATA;
  wire hit_d_data = addr == `PIO_OFS_PORT_D_DATA;
  wire hit_e_data = addr == `PIO_OFS_PORT_E_DATA;
  wire hit_a_dir  = addr == `PIO_OFS_PORT_A_DIR;
  wire hit_b_dir  = addr == `PIO_OFS_PORT_B_DIR;
  wire hit_c_dir  = addr == `PIO_OFS_PORT_C_DIR;
  wire hit_d_dir  = addr == `PIO_OFS_PORT_D_DIR;
  wire hit_e_dir  = addr == `PIO_OFS_PORT_E_DIR;
  wire hit_a_pu   = addr == `PIO_OFS_PORT_A_PULLUP;
  wire hit_c_pu   = addr == `PIO_OFS_PORT_C_PULLUP;
  wire hit_d_pu   = addr == `PIO_OFS_PORT_D_PULLUP;

  // =====================================================================
  // Per-port state
  logic [3:0] a_rd;
  logic [3:0] a_dir;
  logic [3:0] a_pu;
  logic [5:0] b_rd;
  logic [5:0] b_dir;
  logic [1:0] c_rd;
  logic [1:0] c_dir;
  logic [1:0] c_pu;
  logic [6:0] d_rd;
  logic [6:0] d_dir;
  logic [6:0] d_pu;
  logic [1:0] e_rd;
  logic [1:0] e_dir;

  pio_slice #(.W(`PIO_WIDTH_A), .HAS_PU(1'b1)) u_port_a (
    .clk      (clk),
    .rst_b    (rst_b),
    .wr_data  (wr_strobe && hit_a_data),
    .wr_dir   (wr_strobe && hit_a_dir),
    .wr_pu    (wr_strobe && hit_a_pu),
    .wdata    (wdata[3:0]),
    .pin_in   (port_a_in),
    .pin_out  (port_a_out),
    .pin_oe   (port_a_oe),
    .pull_on  (port_a_pullup),
    .alt_en   (keypad_irq_enables),
    .alt_out  (4'h0),
    .alt_oe   (4'h0),
    .rd_value (a_rd),
    .dir      (a_dir),
    .pu       (a_pu)
  );

  // Converter channel forces its pin to input, overriding the direction bit
  pio_slice #(.W(`PIO_WIDTH_B), .HAS_PU(1'b0)) u_port_b (
    .clk      (clk),
    .rst_b    (rst_b),
    .wr_data  (wr_strobe && hit_b_data),
    .wr_dir   (wr_strobe && hit_b_dir),
    .wr_pu    (1'b0),
    .wdata    (wdata[5:0]),
    .pin_in   (port_b_in),
    .pin_out  (port_b_out),
    .pin_oe   (port_b_oe),
    .pull_on  (),
    .alt_en   (converter_channel_select),
    .alt_out  (6'h00),
    .alt_oe   (6'h00),
    .rd_value (b_rd),
    .dir      (b_dir),
    .pu       ()
  );

  pio_slice #(.W(`PIO_WIDTH_C), .HAS_PU(1'b1)) u_port_c (
    .clk      (clk),
    .rst_b    (rst_b),
    .wr_data  (wr_strobe && hit_c_data),
    .wr_dir   (wr_strobe && hit_c_dir),
    .wr_pu    (wr_strobe && hit_c_pu),
    .wdata    (wdata[1:0]),
    .pin_in   (port_c_in),
    .pin_out  (port_c_out),
    .pin_oe   (port_c_oe),
    .pull_on  (port_c_pullup),
    .alt_en   (2'h0),
    .alt_out  (2'h0),
    .alt_oe   (2'h0),
    .rd_value (c_rd),
    .dir      (c_dir),
    .pu       (c_pu)
  );

  pio_slice #(.W(`PIO_WIDTH_D), .HAS_PU(1'b1)) u_port_d (
    .clk      (clk),
    .rst_b    (rst_b),
    .wr_data  (wr_strobe && hit_d_data),
    .wr_dir   (wr_strobe && hit_d_dir),
    .wr_pu    (wr_strobe && hit_d_pu),
    .wdata    (wdata[6:0]),
    .pin_in   (port_d_in),
    .pin_out  (port_d_out),
    .pin_oe   (port_d_oe),
    .pull_on  (port_d_pullup),
    .alt_en   (port_d_alt_en),
    .alt_out  (port_d_alt_out),
    .alt_oe   (port_d_alt_oe),
    .rd_value (d_rd),
    .dir      (d_dir),
    .pu       (d_pu)
  );

  pio_slice #(.W(`PIO_WIDTH_E), .HAS_PU(1'b0)) u_port_e (
    .clk      (clk),
    .rst_b    (rst_b),
    .wr_data  (wr_strobe && hit_e_data),
    .wr_dir   (wr_strobe && hit_e_dir),
    .wr_pu    (1'b0),
    .wdata    (wdata[1:0]),
    .pin_in   (port_e_in),
    .pin_out  (port_e_out),
    .pin_oe   (port_e_oe),
    .pull_on  (),
    .alt_en   (port_e_alt_en),
    .alt_out  (port_e_alt_out),
    .alt_oe   (port_e_alt_oe),
    .rd_value (e_rd),
    .dir      (e_dir),
    .pu       ()
  );

  // =====================================================================
  // Read mux
  // Upper bits are constant zero, so stray writes there cannot show up
  wire pio_pkg::pio_byte_t val_a_data = {4'h0, a_rd};
  wire pio_pkg::pio_byte_t val_b_data = {2'h0, b_rd};
  wire pio_pkg::pio_byte_t val_c_data = {6'h00, c_rd};
  wire pio_pkg::pio_byte_t val_d_data = {1'h0, d_rd};
  wire pio_pkg::pio_byte_t val_e_data = {6'h00, e_rd};
  wire pio_pkg::pio_byte_t val_a_dir  = {4'h0, a_dir};
  wire pio_pkg::pio_byte_t val_b_dir  = {2'h0, b_dir};
  wire pio_pkg::pio_byte_t val_c_dir  = {6'h00, c_dir};
  wire pio_pkg::pio_byte_t val_d_dir  = {1'h0, d_dir};
  wire pio_pkg::pio_byte_t val_e_dir  = {6'h00, e_dir};
  wire pio_pkg::pio_byte_t val_a_pu   = {4'h0, a_pu};
  wire pio_pkg::pio_byte_t val_c_pu   = {6'h00, c_pu};
  wire pio_pkg::pio_byte_t val_d_pu   = {1'h0, d_pu};

  // Unmapped offsets read as zero
  wire pio_pkg::pio_byte_t next_rd_data =
      ({8{hit_a_data}} & val_a_data) | ({8{hit_b_data}} & val_b_data) |
      ({8{hit_c_data}} & val_c_data) | ({8{hit_d_data}} & val_d_data) |
      ({8{hit_e_data}} & val_e_data) | ({8{hit_a_dir}}  & val_a_dir)  |
      ({8{hit_b_dir}}  & val_b_dir)  | ({8{hit_c_dir}}  & val_c_dir)  |
      ({8{hit_d_dir}}  & val_d_dir)  | ({8{hit_e_dir}}  & val_e_dir)  |
      ({8{hit_a_pu}}   & val_a_pu)   | ({8{hit_c_pu}}   & val_c_pu)   |
      ({8{hit_d_pu}}   & val_d_pu);

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!rst_b || !rd_strobe)
    begin
      rd_data <= `PIO_RESET_RDATA;
    end
    else
    begin
      rd_data <= next_rd_data;
    end
  end

  // =====================================================================
  // Pin levels handed to the sharing modules
  // Registered so each level handed to a sharing module comes from a flip-flop; costs one cycle
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      keypad_inputs <= 4'h0;
      port_d_alt_in <= 7'h00;
      port_e_alt_in <= 2'h0;
    end
    else
    begin
      keypad_inputs <= port_a_in & keypad_irq_enables;
      port_d_alt_in <= port_d_in;
      port_e_alt_in <= port_e_in;
    end
  end

  // =====================================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // No reset here: the copy must outlive a reset to judge the latch
  logic       rst_seen;
  logic       a_seen;
  logic [3:0] a_keep;
  always_ff @(posedge clk)
  begin
    rst_seen <= !rst_b;
    if (wr_strobe && hit_a_data)
    begin
      a_seen <= 1'b1;
      a_keep <= wdata[3:0];
    end
  end

  // First cycle after reset is released
  sequence s_reset_pulse;
    rst_seen && rst_b;
  endsequence

  sequence s_dir_a0_set_with_pu;
    wr_strobe && hit_a_dir && wdata[0] && a_pu[0];
  endsequence

  AST_DIR_RESET_ZERO: assert property (
    rst_seen |-> (a_dir == 4'h0 && b_dir == 6'h00 && c_dir == 2'h0 &&
                  d_dir == 7'h00 && e_dir == 2'h0 && port_a_oe == 4'h0))
    else $error("direction bits not cleared by reset");

  AST_PULLUP_RESET_ZERO: assert property (
    rst_seen |-> (a_pu == 4'h0 && c_pu == 2'h0 && d_pu == 7'h00))
    else $error("pullup enables not cleared by reset");

  AST_PULLUP_OFF_ON_OUTPUT: assert property (
    s_dir_a0_set_with_pu |=> !port_a_pullup[0] && port_a_oe[0] != keypad_irq_enables[0])
    else $error("pullup stayed on after pin turned output");

  AST_PULLUP_RETURNS: assert property (
    (wr_strobe && hit_c_dir && !wdata[1] && c_dir[1] && c_pu[1] && !(wr_strobe && hit_c_pu))
      |=> port_c_pullup[1])
    else $error("pullup did not return on input");

  AST_DIR_DRIVES_PIN: assert property (
    (wr_strobe && hit_c_dir && wdata[0]) |=> port_c_oe[0] ##1 (port_c_oe[0] || c_dir[0] == 1'b0))
    else $error("direction one did not enable the driver");

  AST_READ_PIN_OR_LATCH: assert property (
    (rd_strobe && hit_c_data) |=> rd_data == {6'h00, $past(c_dir) & $past(port_c_out) |
                                              ~$past(c_dir) & $past(port_c_in)})
    else $error("port read did not pick latch or pin by direction");

  AST_LATCH_SURVIVES_RESET: assert property (
    s_reset_pulse ##0 a_seen |-> u_port_a.latch == a_keep)
    else $error("port latch lost its value");

  AST_UPPER_READ_ZERO: assert property (
    rd_strobe && (hit_c_dir || hit_e_data || hit_e_dir || hit_c_pu)
      |=> rd_data[7:2] == 6'h00)
    else $error("unimplemented bits read as one");

  AST_PORT_D_TOP_ZERO: assert property (
    rd_strobe && (hit_d_dir || hit_d_pu) |=> !rd_data[7])
    else $error("port d bit 7 read as one");

  AST_KEYPAD_INPUT: assert property (
    keypad_irq_enables[1] |-> !port_a_oe[1] ##1 keypad_inputs[1] == $past(port_a_in[1]))
    else $error("keypad pin not an interrupt input");

  AST_E_LATCH_WRITE: assert property (
    (wr_strobe && hit_e_data) ##1 (e_dir == 2'h3 && port_e_alt_en == 2'h0)
      |-> port_e_out == $past(wdata[1:0]))
    else $error("port e latch not written");

  AST_UNMAPPED_ZERO: assert property (
    rd_strobe && addr > `PIO_OFS_PORT_D_PULLUP |=> rd_data == 8'h00)
    else $error("unmapped read not zero");

endmodule

// *** src/pio_defines.svh ***
// Register offsets, port widths and reset values of the parallel ports.
// Assumes an 8-bit register port with byte-wide data; included by bare name.
`ifndef PIO_DEFINES_SVH
`define PIO_DEFINES_SVH

// =====================================================================
// Register offsets
`define PIO_OFS_PORT_A_DATA   8'h00
`define PIO_OFS_PORT_B_DATA   8'h01
`define PIO_OFS_PORT_C_DATA   8'h02
`define PIO_OFS_PORT_D_DATA   8'h03
`define PIO_OFS_PORT_A_DIR    8'h04
`define PIO_OFS_PORT_B_DIR    8'h05
`define PIO_OFS_PORT_C_DIR    8'h06
`define PIO_OFS_PORT_D_DIR    8'h07
`define PIO_OFS_PORT_E_DATA   8'h08
`define PIO_OFS_PORT_E_DIR    8'h0C
`define PIO_OFS_PORT_A_PULLUP 8'h0D
`define PIO_OFS_PORT_C_PULLUP 8'h0E
`define PIO_OFS_PORT_D_PULLUP 8'h0F

// =====================================================================
// Port widths
`define PIO_WIDTH_A 4
`define PIO_WIDTH_B 6
`define PIO_WIDTH_C 2
`define PIO_WIDTH_D 7
`define PIO_WIDTH_E 2

// =====================================================================
// Reset values
`define PIO_RESET_DIR    8'h00
`define PIO_RESET_PULLUP 8'h00
`define PIO_RESET_RDATA  8'h00

`endif

// *** src/pio_pkg.sv ***
// Types shared by the parallel port design files.
// Assumes nothing beyond a SystemVerilog compiler.
package pio_pkg;

  // =====================================================================
  // Register bus data
  typedef logic [7:0] pio_byte_t;

  // =====================================================================
  // Register bus address
  typedef logic [7:0] pio_addr_t;

endpackage

// *** src/pio_slice.sv ***
// One parallel port: data latches, direction bits, optional pullup enables.
// Assumes synchronous pin inputs and single-cycle write strobes.
`timescale 1ns/100ps
`include "pio_defines.svh"

module pio_slice #(
  parameter int W      = 8,
  parameter bit HAS_PU = 1'b1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Register writes
  input  wire logic         wr_data,
  input  wire logic         wr_dir,
  input  wire logic         wr_pu,
  input  wire logic [W-1:0] wdata,
  // Pins
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe,
  output logic      [W-1:0] pull_on,
  // Shared module override
  input  wire logic [W-1:0] alt_en,
  input  wire logic [W-1:0] alt_out,
  input  wire logic [W-1:0] alt_oe,
  // State seen by software
  output logic      [W-1:0] rd_value,
  output logic      [W-1:0] dir,
  output logic      [W-1:0] pu
);

  logic [W-1:0] latch;

  // =====================================================================
  // Storage
  // Latch has no reset: contents survive a reset
  always_ff @(posedge clk)
  begin
    if (wr_data)
    begin
      latch <= wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      dir <= W'(`PIO_RESET_DIR);
    end
    else if (wr_dir)
    begin
      dir <= wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b || !HAS_PU)
    begin
      pu <= W'(`PIO_RESET_PULLUP);
    end
    else if (wr_pu)
    begin
      pu <= wdata;
    end
  end

  // =====================================================================
  // Per-pin logic
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_pin
      assign pin_out[i]  = alt_en[i] ? alt_out[i] : latch[i];
      assign pin_oe[i]   = alt_en[i] ? alt_oe[i] : dir[i];
      // Pullup follows the direction bit alone, so it comes back on input
      assign pull_on[i]  = pu[i] & ~dir[i];
      assign rd_value[i] = dir[i] ? latch[i] : pin_in[i];
    end
  endgenerate

endmodule

// *** verif/pio_pin_model.sv ***
// Pin-side model of one port: resolves the pad level seen by the block.
// Assumes the bench supplies an external driver per pin and one clock.
`timescale 1ns/100ps

module pio_pin_model #(
  parameter int W = 8
) (
  // Clock
  input  wire logic         clk,
  // Block side
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] pu,
  // External driver
  input  wire logic [W-1:0] ext,
  input  wire logic [W-1:0] ext_en,
  // Resolved pad
  output logic      [W-1:0] level
);
  // =====================================================================
  // Pad resolution
  // A floating pad toggles every cycle, so no read can pass by luck
  logic [W-1:0] last = '0;

  always_ff @(posedge clk)
  begin
    last <= level;
  end

  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      level[i] = oe[i] ? out[i] : ext_en[i] ? ext[i] : pu[i] ? 1'b1 : ~last[i];
    end
  end
endmodule

// *** verif/parallel_io_ports_tb_top.sv ***
// Self-checking bench of the parallel ports: register port, pins, sharing.
// Assumes the pin model above and the register map of the defines header.
`timescale 1ns/100ps
`include "pio_defines.svh"

module parallel_io_ports_tb_top;
  // =====================================================================
  // Signals
  logic               clk = 1'b0;
  logic               rst_b = 1'b0;
  pio_pkg::pio_addr_t addr = 8'h00;
  pio_pkg::pio_byte_t wdata = 8'h00;
  logic               wr_strobe = 1'b0;
  logic               rd_strobe = 1'b0;
  pio_pkg::pio_byte_t rd_data;
  logic [3:0]         a_in, a_out, a_oe, a_pu, kp_en = 4'h0, kp_in;
  logic [5:0]         b_in, b_out, b_oe, ch_sel = 6'h00;
  logic [1:0]         c_in, c_out, c_oe, c_pu;
  logic [6:0]         d_in, d_out, d_oe, d_pu, d_in_alt;
  logic [6:0]         d_en = 7'h00, d_aout = 7'h00, d_aoe = 7'h00;
  logic [1:0]         e_in, e_out, e_oe, e_in_alt;
  logic [1:0]         e_en = 2'h0, e_aout = 2'h0, e_aoe = 2'h0;
  logic [6:0]         ext = 7'h00, ext_en = 7'h00;
  // Board pull resistors on the ports that have no pullup of their own
  logic [6:0]         ext_pu = 7'h00;
  int                 n_mismatch = 0;
  int                 comparisons = 0;
  pio_pkg::pio_byte_t rv;

  always #5 clk = ~clk;

  pio_ports dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rd_data(rd_data), .port_a_in(a_in), .port_a_out(a_out),
    .port_a_oe(a_oe), .port_a_pullup(a_pu), .port_b_in(b_in), .port_b_out(b_out),
    .port_b_oe(b_oe), .port_c_in(c_in), .port_c_out(c_out), .port_c_oe(c_oe),
    .port_c_pullup(c_pu), .port_d_in(d_in), .port_d_out(d_out), .port_d_oe(d_oe),
    .port_d_pullup(d_pu), .port_e_in(e_in), .port_e_out(e_out), .port_e_oe(e_oe),
    .keypad_irq_enables(kp_en), .keypad_inputs(kp_in), .converter_channel_select(ch_sel),
    .port_d_alt_en(d_en), .port_d_alt_out(d_aout), .port_d_alt_oe(d_aoe),
    .port_d_alt_in(d_in_alt), .port_e_alt_en(e_en), .port_e_alt_out(e_aout),
    .port_e_alt_oe(e_aoe), .port_e_alt_in(e_in_alt));

  pio_pin_model #(.W(4)) pm_a (.clk(clk), .oe(a_oe), .out(a_out), .pu(a_pu), .ext(ext[3:0]),
    .ext_en(ext_en[3:0]), .level(a_in));
  pio_pin_model #(.W(6)) pm_b (.clk(clk), .oe(b_oe), .out(b_out), .pu(ext_pu[5:0]),
    .ext(ext[5:0]), .ext_en(ext_en[5:0]), .level(b_in));
  pio_pin_model #(.W(2)) pm_c (.clk(clk), .oe(c_oe), .out(c_out), .pu(c_pu), .ext(ext[1:0]),
    .ext_en(ext_en[1:0]), .level(c_in));
  pio_pin_model #(.W(7)) pm_d (.clk(clk), .oe(d_oe), .out(d_out), .pu(d_pu), .ext(ext),
    .ext_en(ext_en), .level(d_in));
  pio_pin_model #(.W(2)) pm_e (.clk(clk), .oe(e_oe), .out(e_out), .pu(ext_pu[1:0]),
    .ext(ext[1:0]), .ext_en(ext_en[1:0]), .level(e_in));

  // =====================================================================
  // Shared tasks
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_strobe <= 1'b1;
    @(posedge clk);
    wr_strobe <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_strobe <= 1'b0;
    #1;
    d = rd_data;
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    #1;
  endtask

  task automatic close_out();
    if (n_mismatch == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // =====================================================================
  // Scenarios
  task automatic t_masks();
    logic [7:0] ofs [6] = '{8'h06, 8'h07, 8'h0C, 8'h0D, 8'h0E, 8'h0F};
    logic [7:0] msk [6] = '{8'h03, 8'h7F, 8'h03, 8'h0F, 8'h03, 8'h7F};
    chk("oe after reset", {a_oe, b_oe[3:0]}, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      rd(ofs[i], rv);
      chk("reset value", rv, 8'h00);
      wr(ofs[i], 8'hFF);
      rd(ofs[i], rv);
      chk("implemented bits", rv, msk[i]);
    end
    wr(8'h10, 8'hFF);
    rd(8'h10, rv);
    chk("unmapped read", rv, 8'h00);
  endtask

  task automatic t_latch_keep();
    wr(`PIO_OFS_PORT_A_DATA, 8'hF5);
    wr(`PIO_OFS_PORT_E_DATA, 8'hFE);
    do_reset();
    chk("dir D after reset", {1'b0, d_oe}, 8'h00);
    chk("pullup D after reset", {1'b0, d_pu}, 8'h00);
    wr(`PIO_OFS_PORT_A_DIR, 8'h0F);
    wr(`PIO_OFS_PORT_E_DIR, 8'h03);
    chk("port A latch", {a_oe, a_out}, 8'hF5);
    chk("port E latch", {e_oe, e_out}, 8'h0E);
    rd(`PIO_OFS_PORT_E_DATA, rv);
    chk("port E read latch", rv, 8'h02);
  endtask

  task automatic t_input_read();
    @(posedge clk);
    ext <= 7'h01;
    ext_en <= 7'h7F;
    wr(`PIO_OFS_PORT_E_DIR, 8'h02);
    rd(`PIO_OFS_PORT_E_DATA, rv);
    chk("port E mixed read", rv, 8'h03);
    wr(`PIO_OFS_PORT_A_DIR, 8'h00);
    wr(`PIO_OFS_PORT_A_DATA, 8'h0A);
    rd(`PIO_OFS_PORT_A_DATA, rv);
    chk("port A pin read", rv, 8'h01);
  endtask

  task automatic t_pullup();
    @(posedge clk);
    ext_en <= 7'h00;
    ext_pu <= 7'h3F;
    wr(`PIO_OFS_PORT_A_PULLUP, 8'h0F);
    wr(`PIO_OFS_PORT_C_PULLUP, 8'h03);
    wr(`PIO_OFS_PORT_D_PULLUP, 8'h7F);
    chk("pullup A on", {4'h0, a_pu}, 8'h0F);
    rd(`PIO_OFS_PORT_A_DATA, rv);
    chk("pulled pin read", rv, 8'h0F);
    rd(`PIO_OFS_PORT_B_DATA, rv);
    chk("port B board pull read", rv, 8'h3F);
    wr(`PIO_OFS_PORT_A_DIR, 8'h05);
    wr(`PIO_OFS_PORT_C_DIR, 8'h01);
    wr(`PIO_OFS_PORT_D_DIR, 8'h0F);
    chk("pullup A off", {4'h0, a_pu}, 8'h0A);
    chk("pullup C off", {6'h00, c_pu}, 8'h02);
    chk("pullup D off", {1'b0, d_pu}, 8'h70);
    wr(`PIO_OFS_PORT_C_DATA, 8'h02);
    rd(`PIO_OFS_PORT_C_DATA, rv);
    chk("port C mixed read", rv, 8'h02);
    wr(`PIO_OFS_PORT_C_DIR, 8'h02);
    wr(`PIO_OFS_PORT_C_DIR, 8'h00);
    chk("pullup C back", {6'h00, c_pu}, 8'h03);
    wr(`PIO_OFS_PORT_A_DIR, 8'h00);
    chk("pullup A back", {4'h0, a_pu}, 8'h0F);
  endtask

  task automatic t_keypad();
    wr(`PIO_OFS_PORT_A_DATA, 8'h05);
    wr(`PIO_OFS_PORT_A_DIR, 8'h0F);
    @(posedge clk);
    ext <= 7'h0A;
    ext_en <= 7'h7F;
    kp_en <= 4'h3;
    @(posedge clk);
    @(posedge clk);
    #1;
    chk("keypad forces input", {4'h0, a_oe}, 8'h0C);
    chk("keypad inputs", {4'h0, kp_in}, 8'h02);
    rd(`PIO_OFS_PORT_A_DATA, rv);
    chk("port A read under keypad", rv, 8'h05);
  endtask

  task automatic t_sharing();
    wr(`PIO_OFS_PORT_B_DATA, 8'h3F);
    wr(`PIO_OFS_PORT_B_DIR, 8'h3F);
    @(posedge clk);
    ch_sel <= 6'h05;
    d_en <= 7'h7F;
    d_aoe <= 7'h0F;
    d_aout <= 7'h05;
    e_en <= 2'h3;
    e_aoe <= 2'h1;
    e_aout <= 2'h1;
    ext <= 7'h72;
    @(posedge clk);
    @(posedge clk);
    #1;
    chk("converter oe", {2'h0, b_oe}, 8'h3A);
    chk("converter out", {2'h0, b_out}, 8'h3A);
    chk("port D shared drive", {1'b0, d_oe}, 8'h0F);
    chk("port D shared out", {4'h0, d_out[3:0]}, 8'h05);
    chk("port D shared in", {1'b0, d_in_alt}, 8'h75);
    chk("port E shared", {2'h0, e_oe, e_in_alt, e_out[0], 1'b0}, 8'h1E);
    rd(`PIO_OFS_PORT_B_DATA, rv);
    chk("port B read latch", rv, 8'h3F);
  endtask

  // =====================================================================
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    t_masks();
    t_latch_keep();
    t_input_read();
    t_pullup();
    t_keypad();
    t_sharing();
    close_out();
  end
endmodule
